// File: rtl/rsr_pkg.sv
// Purpose: Shared constants and types for the serial register front end of the clock.
// Assumes: 50 MHz system clock; 32.768 kHz time base arrives as a pin level.
// Notes:   Command codes are the full 8-bit command bytes, bit 0 = read.
package rsr_pkg;
  // Command bytes
  localparam logic [7:0] CMD_CLK_BURST_WR = 8'h00;
  localparam logic [7:0] CMD_CLK_BURST_RD = 8'h01;
  localparam logic [7:0] CMD_SEC_WR       = 8'h02;
  localparam logic [7:0] CMD_CTRL_WR      = 8'h10;
  localparam logic [7:0] CMD_CTRL_RD      = 8'h11;
  localparam logic [7:0] CMD_STAT_RD      = 8'h19;
  localparam logic [7:0] CMD_RAM_FIRST    = 8'h3e;
  localparam logic [7:0] CMD_RAM_LAST     = 8'hfd;
  localparam logic [7:0] CMD_RAM_BURST_WR = 8'hfe;
  localparam logic [7:0] CMD_RAM_BURST_RD = 8'hff;
  // Slave ID (arbitrary value, no part identity)
  localparam logic [6:0] SLAVE_ID         = 7'h50;
  // Sizes
  localparam int RAM_DEPTH  = 96;
  localparam int CLK_REGS   = 8;
  // Clock register indices (command bits 4:1 minus one)
  localparam logic [2:0] IX_SEC = 3'd0;
  localparam logic [2:0] IX_MIN = 3'd1;
  localparam logic [2:0] IX_HR  = 3'd2;
  localparam logic [2:0] IX_DATE = 3'd3;
  localparam logic [2:0] IX_MON = 3'd4;
  localparam logic [2:0] IX_DAY = 3'd5;
  localparam logic [2:0] IX_YR  = 3'd6;
  localparam logic [2:0] IX_CTRL = 3'd7;
  // Reset values
  localparam logic [7:0] RST_SEC  = 8'h00;
  localparam logic [7:0] RST_MIN  = 8'h00;
  localparam logic [7:0] RST_HR   = 8'h00;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MON  = 8'h01;
  localparam logic [7:0] RST_DAY  = 8'h01;
  localparam logic [7:0] RST_YR   = 8'h70;
  localparam logic [7:0] RST_CTRL = 8'h48;
  // Setup register fields
  localparam int B_BKP_FLASH = 0;
  localparam int B_LOW_FLASH = 1;
  localparam int B_WD_PERIOD = 2;
  localparam int B_WATCHDOG_ENABLE_BIT     = 3;
  localparam int B_RATIO     = 5;
  localparam int B_OSC_CHK   = 6;
  localparam int B_GUARD     = 7;
  // Hours fields
  localparam int B_H12 = 7;
  localparam int B_PM  = 5;
  // Time base
  localparam int XTAL_DIV = 32768;
  // Write buffer entry
  typedef struct packed {
    logic       ram;   // 1 = RAM, 0 = clock register
    logic [6:0] addr;  // RAM index or clock register index
    logic [7:0] data;
  } rsr_wr_t;
endpackage : rsr_pkg

// File: rtl/rsr_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, common enable.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ns
`default_nettype none
module rsr_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         ce_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out,
  input  wire logic         flush_in
);
  localparam int AW = $clog2(D);
  // Elaboration check on the depth
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("rsr_fifo depth must be power of two");
  end
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;
  wire full  = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire empty = (wp_reg == rp_reg);
  wire push  = in_valid_in && !full && ce_in;
  wire pop   = out_ready_in && !empty && ce_in;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rp_reg[AW-1:0]];
  // Storage
  always_ff @(posedge clk_in) begin
    if (push) mem[wp_reg[AW-1:0]] <= in_data_in;
  end
  // Pointers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (ce_in && flush_in) begin
      rp_reg <= wp_reg;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop)  rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule : rsr_fifo
`default_nettype wire

// File: rtl/rsr_core.sv
// Purpose: Serial-bus register front end with BCD timekeeping and scratchpad RAM.
// Assumes: SCL, SDA and 32.768 kHz time base are pins, synchronised here.
// Notes:   Writes are held in a FIFO and committed after STOP.
//
// Overview of operation
// R1 - Clock burst read returns seconds..year then setup, eight bytes as a group.
// R2 - Burst read command snapshots all seven time counters at once.
// R3 - Time writes buffer until STOP; incomplete write discards buffer.
// R4 - Buffered load never coincides with a seconds tick.
// R5 - Seconds write or clock burst write clears the sub-second divider.
// R6 - Clock burst write commits only when all eight bytes arrived.
// R7 - Master writes remaining time registers within one second.
// R8 - Weekday increments at midnight as a plain sequential code.
// R9 - Timeout starts at 1Hz edge after START; next edge returns idle.
// R10 - STOP before that edge halts timeout, waits for START.
// R11 - Setup bits D0, D1 enable 1Hz flashing of battery outputs.
// R12 - Setup D3 enables watchdog, D2 selects its period.
// R13 - Setup D5 selects internal or external battery ratio.
// R14 - Setup D6 enables oscillator failure checking.
// R15 - Write guard blocks all writes except to the setup register.
// R16 - Write guard set blocks whole clock burst write.
// R17 - Hours D7 selects 12-hour mode; D5 is PM or twenty-hour bit.
// R18 - Command 00h is clock burst write, 01h clock burst read.
// R19 - 96 RAM bytes; even 3Eh..FCh write, odd 3Fh..FDh read.
// R20 - FEh/FFh RAM burst from first location; complete bytes stored.
// R21 - RAM burst read continues to 96 bytes or master stop.
// R22 - Status D0..D3 zero; D4 alarm, D5 low battery, D6 power lost, D7 osc fail.
// R23 - Command bits 7..1 select location, bit 0 selects read.
// R24 - Mid-byte STOP drops partial RAM byte, aborts clock burst.
// R25 - Single time read latches counters at command acknowledge.
// R26 - One-second tick from 32.768 kHz; BCD counting with calendar.
`timescale 1ns/1ns
`default_nettype none
module rsr_core
  import rsr_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic mclk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  input  wire logic xtal_in,
  input  wire logic alarm_flag_in,
  input  wire logic low_battery_flag_in,
  input  wire logic power_lost_in,
  input  wire logic osc_failure_flag_in,
  input  wire logic backup_active_in,
  output logic      backup_active_out,
  output logic      low_battery_out,
  output logic      watchdog_enable_bit_out,
  output logic      watchdog_period_select_out,
  output logic      battery_ratio_select_out,
  output logic      osc_fail_check_enable_out
);
  // Synchronisers
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] xt_s;
  logic       scl_d;
  logic       sda_d;
  logic       xt_d;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_s <= 2'b11; sda_s <= 2'b11; xt_s <= 2'b00;
      scl_d <= 1'b1;  sda_d <= 1'b1;  xt_d <= 1'b0;
    end else if (ce_in) begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      xt_s  <= {xt_s[0], xtal_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
      xt_d  <= xt_s[1];
    end
  end
  wire scl     = scl_s[1];
  wire sda     = sda_s[1];
  wire scl_r   = scl && !scl_d;
  wire scl_f   = !scl && scl_d;
  wire start_c = scl && scl_d && sda_d && !sda;
  wire stop_c  = scl && scl_d && !sda_d && sda;
  wire xt_r    = xt_s[1] && !xt_d;

  // Timekeeping state
  logic [7:0] tk_reg [CLK_REGS];
  logic [7:0] snap_reg [CLK_REGS];
  logic [14:0] pre_reg;
  logic        clr_pre;
  wire  tick = xt_r && (pre_reg == 15'(XTAL_DIV - 1));
  wire  hz_hi = pre_reg[14];                          // 1Hz square wave
  wire  hz_r  = xt_r && (pre_reg == 15'(XTAL_DIV / 2 - 1));

  // BCD increment with wrap
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                         input logic [7:0] base);
    logic [7:0] r;
    r = v;
    if (v == top) r = base;
    else if (v[3:0] == 4'h9) r = {v[7:4] + 4'h1, 4'h0};
    else r = {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction
  logic [7:0] days_max;
  wire  [7:0] mon = tk_reg[IX_MON];
  wire  [7:0] yr  = tk_reg[IX_YR];
  wire  leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                      : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8));
  always_comb begin
    unique case (mon)
      8'h02:                         days_max = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11:   days_max = 8'h30;
      default:                       days_max = 8'h31;
    endcase
  end
  // Hours rollover, both modes R17
  wire [7:0] hr = tk_reg[IX_HR];
  logic [7:0] hr_next;
  logic       midnight;
  always_comb begin
    midnight = 1'b0;
    if (hr[B_H12]) begin                                   // R17
      if (hr[4:0] == 5'h11) begin
        hr_next  = {hr[7:6], ~hr[B_PM], 5'h12};
        midnight = hr[B_PM];
      end else if (hr[4:0] == 5'h12) hr_next = {hr[7:5], 5'h01};
      else hr_next = {hr[7:5], 5'(bcd_inc({3'h0, hr[4:0]}, 8'h12, 8'h01))};
    end else begin
      midnight = (hr[5:0] == 6'h23);
      hr_next  = {2'b00, 6'(bcd_inc({2'b00, hr[5:0]}, 8'h23, 8'h00))};
    end
  end

  // Write buffer
  rsr_wr_t    wq_in;
  rsr_wr_t    wq_out;
  logic       wq_push;
  logic       wq_rdy;
  logic       wq_vld;
  logic       wq_pop;
  logic       wq_flush;
  rsr_fifo #(.W($bits(rsr_wr_t)), .D(FIFO_DEPTH)) u_wq (
    .clk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .in_valid_in(wq_push), .in_ready_out(wq_rdy), .in_data_in(wq_in),
    .out_valid_out(wq_vld), .out_ready_in(wq_pop), .out_data_out(wq_out),
    .flush_in(wq_flush)
  );

  // Bus engine
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_WDATA, S_RDATA, S_IGN} rsr_st_t;
  rsr_st_t    st_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] cmd_reg;
  logic [6:0] ptr_reg;
  logic       ack_reg;
  logic       rd_nack_reg;
  logic       commit_reg;       // frame has complete write data in queue
  logic       burst_ok_reg;     // clock burst reached eight bytes
  logic       clk_wr_reg;
  logic [1:0] to_reg;           // 0 off, 1 armed, 2 counting
  logic [7:0] rram [RAM_DEPTH];
  logic       drain_reg;
  logic       cmd_ack_reg;      // command byte ack still to come
  // The command ack fall is the latch point, not a data-byte boundary

  wire guard    = tk_reg[IX_CTRL][B_GUARD];
  wire is_cburst = (cmd_reg[7:1] == CMD_CLK_BURST_WR[7:1]);       // R18
  wire is_rburst = (cmd_reg[7:1] == CMD_RAM_BURST_WR[7:1]);       // R20
  wire is_ram   = (cmd_reg >= CMD_RAM_FIRST) && (cmd_reg <= CMD_RAM_LAST); // R19
  wire is_clk   = (cmd_reg[7:5] == 3'b000) && (cmd_reg[4:1] >= 4'h1) && (cmd_reg[4:1] <= 4'h8);
  wire [7:0] ram_ix  = 8'((cmd_reg - CMD_RAM_FIRST) >> 1);
  wire [7:0] byte_in = {sh_reg[6:0], sda};
  // Read byte selection
  wire [7:0] sts_val = {osc_failure_flag_in, power_lost_in, low_battery_flag_in,
                        alarm_flag_in, 4'h0};                     // R22
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (is_cburst) rd_val = (ptr_reg < 7'(CLK_REGS)) ? snap_reg[ptr_reg[2:0]] : 8'h00; // R1
    else if (is_rburst) rd_val = (ptr_reg < 7'(RAM_DEPTH)) ? rram[ptr_reg] : 8'hff;     // R21
    else if (is_ram) rd_val = rram[ram_ix[6:0]];
    else if (cmd_reg == CMD_STAT_RD) rd_val = sts_val;
    else if (is_clk) rd_val = snap_reg[3'(cmd_reg[4:1] - 4'h1)];
  end
  // Destination of a written byte (R23: bits 7..1 select, bit 0 read)
  assign wq_in.ram  = is_ram || is_rburst;
  assign wq_in.addr = is_rburst ? ptr_reg : is_ram ? ram_ix[6:0] :
                      is_cburst ? ptr_reg : 7'(cmd_reg[4:1] - 4'h1);
  assign wq_in.data = byte_in;
  wire ctrl_only = !is_ram && !is_rburst && !is_cburst && (cmd_reg == CMD_CTRL_WR);
  wire wr_allow  = (!guard || ctrl_only)                           // R15 R16
                   && (is_ram || is_clk || (is_cburst && ptr_reg < 7'(CLK_REGS))
                       || (is_rburst && ptr_reg < 7'(RAM_DEPTH)));
  wire byte_done = scl_r && (bit_reg == 4'd7);
  assign wq_push = ce_in && (st_reg == S_WDATA) && byte_done && wr_allow && !drain_reg;
  wire  ack_edge = scl_f && (bit_reg == 4'd8);

  // Serial state machine
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= S_IDLE; bit_reg <= 4'd0; sh_reg <= 8'h00; cmd_reg <= 8'h00;
      ptr_reg <= 7'd0; ack_reg <= 1'b0; rd_nack_reg <= 1'b0;
      commit_reg <= 1'b0; burst_ok_reg <= 1'b0; clk_wr_reg <= 1'b0; to_reg <= 2'd0;
      cmd_ack_reg <= 1'b0;
    end else if (ce_in) begin
      if (start_c) begin
        st_reg <= S_ADDR; bit_reg <= 4'd0; ack_reg <= 1'b0; to_reg <= 2'd1;
        cmd_ack_reg <= 1'b0;
      end else if (stop_c) begin
        st_reg <= S_IDLE; ack_reg <= 1'b0; to_reg <= 2'd0;          // R10
        commit_reg <= commit_reg && (!is_cburst || burst_ok_reg); // R6 R24
      end else if (to_reg == 2'd2 && hz_r) begin
        st_reg <= S_IDLE; ack_reg <= 1'b0; to_reg <= 2'd0;          // R9
        commit_reg <= 1'b0;                                         // R3
      end else begin
        if (to_reg == 2'd1 && hz_r) to_reg <= 2'd2;                 // R9
        if (scl_r && bit_reg < 4'd8) sh_reg <= byte_in;
        if (scl_r) bit_reg <= (bit_reg == 4'd8) ? 4'd0 : bit_reg + 4'd1;
        if (scl_f && bit_reg == 4'd8) ack_reg <= 1'b0;
        if (ack_edge) cmd_ack_reg <= 1'b0;
        if (scl_r && bit_reg == 4'd8 && st_reg == S_RDATA) rd_nack_reg <= sda;
        if (byte_done) begin
          unique case (st_reg)
            S_ADDR: begin
              st_reg  <= (byte_in[7:1] == SLAVE_ID) ? S_CMD : S_IGN;
              ack_reg <= (byte_in[7:1] == SLAVE_ID);
              rd_nack_reg <= 1'b0;
            end
            S_CMD: begin
              cmd_reg <= byte_in; ptr_reg <= 7'd0; ack_reg <= 1'b1;
              st_reg  <= byte_in[0] ? S_RDATA : S_WDATA;            // R23
              cmd_ack_reg <= 1'b1;                                  // R25
              commit_reg <= 1'b0; burst_ok_reg <= 1'b0; clk_wr_reg <= 1'b0;
            end
            S_WDATA: begin
              ack_reg <= wq_rdy;
              ptr_reg <= ptr_reg + 7'd1;
              if (wq_push) commit_reg <= 1'b1;                      // R20
              if (wq_push && !wq_in.ram) clk_wr_reg <= 1'b1;
              if (is_cburst && ptr_reg == 7'(CLK_REGS - 1)) burst_ok_reg <= 1'b1;
            end
            default: ;
          endcase
        end
        // Read pointer steps at data-byte acks only, so byte 0 is sent first
        if (ack_edge && st_reg == S_RDATA && !cmd_ack_reg)
          ptr_reg <= ptr_reg + 7'd1;                                // R21
      end
    end
  end
  // Commit and drain after STOP
  wire sec_write = clk_wr_reg && (is_cburst || cmd_reg == CMD_SEC_WR);
  assign wq_flush = ce_in && ((stop_c && !(commit_reg && (!is_cburst || burst_ok_reg)))
                    || start_c && !drain_reg);                       // R3 R24
  assign wq_pop   = drain_reg && wq_vld && !tick;                    // R4
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) drain_reg <= 1'b0;
    else if (ce_in) begin
      if (st_reg == S_IDLE && commit_reg && !stop_c) drain_reg <= wq_vld;
      else if (!wq_vld) drain_reg <= 1'b0;
    end
  end
  // Ack and read-data driver, open drain
  wire rd_bit = rd_val[3'd7 - bit_reg[2:0]];
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) sda_oe_out <= 1'b0;
    else if (ce_in) begin
      if (st_reg == S_IDLE) sda_oe_out <= 1'b0;                      // R9
      else if (scl_f) begin
        if (bit_reg == 4'd8) sda_oe_out <= ack_reg;
        else if (st_reg == S_RDATA && !rd_nack_reg) sda_oe_out <= !rd_bit;
        else sda_oe_out <= 1'b0;
      end
    end
  end
  assign sda_out = 1'b0;

  // Counters, snapshot, RAM writes
  logic pre_clr_req;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_reg <= '0; pre_clr_req <= 1'b0;
      tk_reg[IX_SEC] <= RST_SEC; tk_reg[IX_MIN] <= RST_MIN; tk_reg[IX_HR] <= RST_HR;
      tk_reg[IX_DATE] <= RST_DATE; tk_reg[IX_MON] <= RST_MON; tk_reg[IX_DAY] <= RST_DAY;
      tk_reg[IX_YR] <= RST_YR; tk_reg[IX_CTRL] <= RST_CTRL;
      for (int i = 0; i < CLK_REGS; i++) snap_reg[i] <= 8'h00;
    end else if (ce_in) begin
      if (pre_clr_req && !drain_reg) begin
        pre_reg <= '0; pre_clr_req <= 1'b0;                         // R5
      end else if (xt_r) pre_reg <= pre_reg + 15'd1;                 // R26
      // Set after clear, so a STOP in the clearing cycle is kept
      if (stop_c && sec_write && commit_reg) pre_clr_req <= 1'b1;
      if (ack_edge && cmd_ack_reg && cmd_reg[0] && (is_cburst || is_clk))
        for (int i = 0; i < CLK_REGS; i++) snap_reg[i] <= tk_reg[i]; // R2 R25
      if (wq_pop && !wq_out.ram) tk_reg[wq_out.addr[2:0]] <= wq_out.data; // R3
      else if (tick) begin                                           // R4
        tk_reg[IX_SEC] <= bcd_inc(tk_reg[IX_SEC], 8'h59, 8'h00);
        if (tk_reg[IX_SEC] == 8'h59) begin
          tk_reg[IX_MIN] <= bcd_inc(tk_reg[IX_MIN], 8'h59, 8'h00);
          if (tk_reg[IX_MIN] == 8'h59) begin
            tk_reg[IX_HR] <= hr_next;
            if (midnight) begin
              tk_reg[IX_DAY] <= bcd_inc(tk_reg[IX_DAY], 8'h07, 8'h01);  // R8
              tk_reg[IX_DATE] <= bcd_inc(tk_reg[IX_DATE], days_max, 8'h01);
              if (tk_reg[IX_DATE] == days_max) begin
                tk_reg[IX_MON] <= bcd_inc(mon, 8'h12, 8'h01);
                if (mon == 8'h12) tk_reg[IX_YR] <= bcd_inc(yr, 8'h99, 8'h00);
              end
            end
          end
        end
      end
    end
  end
  always_ff @(posedge mclk_in) begin
    if (ce_in && wq_pop && wq_out.ram) rram[wq_out.addr] <= wq_out.data; // R20
  end

  // Setup outputs
  wire [7:0] ctl = tk_reg[IX_CTRL];
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      backup_active_out <= 1'b0; low_battery_out <= 1'b0;
      watchdog_enable_bit_out <= 1'b0; watchdog_period_select_out <= 1'b0;
      battery_ratio_select_out <= 1'b0; osc_fail_check_enable_out <= 1'b0;
    end else if (ce_in) begin
      backup_active_out <= backup_active_in && (!ctl[B_BKP_FLASH] || hz_hi);    // R11
      low_battery_out   <= low_battery_flag_in && (!ctl[B_LOW_FLASH] || hz_hi); // R11
      watchdog_enable_bit_out    <= ctl[B_WATCHDOG_ENABLE_BIT];                             // R12
      watchdog_period_select_out <= ctl[B_WD_PERIOD];                         // R12
      battery_ratio_select_out   <= ctl[B_RATIO];                             // R13
      osc_fail_check_enable_out  <= ctl[B_OSC_CHK];                           // R14
    end
  end

  // Assertions
  a_guard_blocks_clk: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R15
    wq_push && guard |-> ctrl_only) else $error("write accepted while guarded");
  a_no_tick_load: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R4
    wq_pop |-> !tick) else $error("load collided with tick");
  a_timeout_idle: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R9
    ce_in && to_reg == 2'd2 && hz_r && !start_c && !stop_c |=> st_reg == S_IDLE)
    else $error("timeout did not idle");
  a_stop_halts: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R10
    ce_in && stop_c && !start_c |=> to_reg == 2'd0 && st_reg == S_IDLE)
    else $error("stop did not halt timeout");
  a_sda_release: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R9
    st_reg == S_IDLE && ce_in |=> !sda_oe_out) else $error("sda held in idle");
  a_status_low: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R22
    sts_val[3:0] == 4'h0) else $error("status low bits nonzero");
  a_burst_commit: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R6
    ce_in && stop_c && is_cburst && !burst_ok_reg |-> wq_flush)
    else $error("short burst not discarded");
  a_only_queue_loads: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R3
    ce_in && st_reg != S_IDLE && !drain_reg |=> $stable(tk_reg[IX_MIN]) || $past(tick))
    else $error("counter changed during frame");
  a_snap_latch: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R2
    ce_in && ack_edge && cmd_ack_reg && cmd_reg[0] && is_cburst
    |=> snap_reg[IX_SEC] == $past(tk_reg[IX_SEC])) else $error("burst snapshot missed");
  a_first_ptr: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R1
    ce_in && ack_edge && cmd_ack_reg |=> ptr_reg == 7'd0)
    else $error("pointer moved at command ack");
  a_pre_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R5
    ce_in && pre_clr_req && !drain_reg |=> pre_reg == '0)
    else $error("prescaler not cleared");
endmodule : rsr_core
`default_nettype wire

// File: bench/rsr_master_model.sv
// Purpose: Serial bus master model that drives SCL and SDA toward the front end.
// Assumes: SDA is wired-AND with a pull-up; SCL high phase lasts 10 clocks, low phase 12.
// Notes:   Each read byte is announced by a one-cycle got_out pulse.
`timescale 1ns/1ns
`default_nettype none
module rsr_master_model (
  input  wire logic  mclk_in,
  input  wire logic  sda_in,
  output logic       scl_out,
  output logic       sda_out,
  output logic       got_out,
  output logic [7:0] byte_out
);
  // Idle bus: both lines released high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    got_out = 1'b0;
    byte_out = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : wt
  // Data changes only while SCL is low and stays still through the high phase
  task automatic bit_x(input logic b, output logic s);
    wt(2);
    sda_out <= b;
    wt(10);
    scl_out <= 1'b1;
    wt(5);
    s = sda_in;
    wt(5);
    scl_out <= 1'b0;
  endtask : bit_x
  // Start: SDA falls while SCL is high
  task automatic start_c;
    wt(10);
    sda_out <= 1'b0;
    wt(10);
    scl_out <= 1'b0;
  endtask : start_c
  // Stop: SDA rises while SCL is high
  task automatic stop_c;
    wt(2);
    sda_out <= 1'b0;
    wt(10);
    scl_out <= 1'b1;
    wt(10);
    sda_out <= 1'b1;
    wt(10);
  endtask : stop_c
  // Byte out MSB first, then SDA released for the acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, ack);
  endtask : wbyte
  // Byte in; the last byte of a read is not acknowledged
  task automatic rbyte(input logic last);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(last, s);
    byte_out <= v;
    got_out <= 1'b1;
    wt(1);
    got_out <= 1'b0;
  endtask : rbyte
endmodule : rsr_master_model
`default_nettype wire

// File: bench/rsr_core_tb_top.sv
// Purpose: Self-checking bench for the serial register front end.
// Assumes: Time base runs near 32.768 kHz, so no seconds tick occurs in the run.
// Notes:   Read results are matched against queued expectations by a watcher.
`timescale 1ns/1ns
`default_nettype none
module rsr_core_tb_top;
  import rsr_pkg::*;
  logic       mclk, rst_n, ce, xtal, alm, lbf, plost, ofail, bkp, a;
  logic       scl, m_sda, got, d_sda, d_oe, bkp_o, lb_o, wde, wdp, rat, occ;
  logic [7:0] rd_byte, v0;
  logic [7:0] wq[8];
  logic [7:0] clk[8];
  logic [7:0] exp_q[$];
  int         n_fail, n_compared, cyc, k;
  wire logic  sda_w;
  // Open-drain data line with pull-up
  assign sda_w = m_sda & (d_oe ? d_sda : 1'b1);
  rsr_core i_rsr_core (.mclk_in(mclk), .nrst_in(rst_n), .ce_in(ce), .scl_in(scl),
    .sda_in(sda_w), .sda_out(d_sda), .sda_oe_out(d_oe), .xtal_in(xtal),
    .alarm_flag_in(alm), .low_battery_flag_in(lbf), .power_lost_in(plost),
    .osc_failure_flag_in(ofail), .backup_active_in(bkp), .backup_active_out(bkp_o),
    .low_battery_out(lb_o), .watchdog_enable_bit_out(wde),
    .watchdog_period_select_out(wdp), .battery_ratio_select_out(rat),
    .osc_fail_check_enable_out(occ));
  rsr_master_model i_rsr_master_model (.mclk_in(mclk), .sda_in(sda_w), .scl_out(scl),
    .sda_out(m_sda), .got_out(got), .byte_out(rd_byte));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // Frame head: start, device id with write, command; both acknowledged
  task automatic head(input logic [7:0] cmd);
    i_rsr_master_model.start_c();
    i_rsr_master_model.wbyte({SLAVE_ID, 1'b0}, a);
    check({7'h00, a}, 8'h00);
    i_rsr_master_model.wbyte(cmd, a);
    check({7'h00, a}, 8'h00);
  endtask : head
  task automatic wr_frame(input logic [7:0] cmd, input int n);
    head(cmd);
    for (int i = 0; i < n; i++) i_rsr_master_model.wbyte(wq[i], a);
    i_rsr_master_model.stop_c();
  endtask : wr_frame
  task automatic rd_frame(input logic [7:0] cmd, input int n);
    head(cmd);
    for (int i = 0; i < n; i++) i_rsr_master_model.rbyte(i == n - 1);
    i_rsr_master_model.stop_c();
  endtask : rd_frame
  // Clock and time base
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    xtal = 1'b0;
    forever #15259 xtal = ~xtal;
  end
  // Watcher: every read byte is checked against the oldest expectation
  always @(posedge mclk) if (got === 1'b1) check(rd_byte, exp_q.pop_front());
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {alm, lbf, plost, ofail, bkp} = 5'h00;
    void'($urandom(96090));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check({4'h0, occ, rat, wdp, wde}, 8'h09);
    exp_q.push_back(RST_CTRL);
    rd_frame(CMD_CTRL_RD, 1);
    // Enable low freezes the outputs; then they follow the inputs
    ce <= 1'b0;
    {alm, lbf, plost, ofail, bkp} <= 5'($urandom) | 5'h09;
    repeat (6) @(posedge mclk);
    check({6'h00, lb_o, bkp_o}, 8'h00);
    ce <= 1'b1;
    repeat (6) @(posedge mclk);
    check({6'h00, lb_o, bkp_o}, {6'h00, lbf, bkp});
    exp_q.push_back({ofail, plost, lbf, alm, 4'h0});
    rd_frame(CMD_STAT_RD, 1);
    // Single RAM writes at first, last and a random location
    for (int j = 0; j < 3; j++) begin
      k = (j == 0) ? 0 : (j == 1) ? 95 : $urandom_range(94, 1);
      wq[0] = 8'($urandom);
      if (j == 0) v0 = wq[0];
      wr_frame(CMD_RAM_FIRST + 8'(2 * k), 1);
      exp_q.push_back(wq[0]);
      rd_frame(CMD_RAM_FIRST + 8'(2 * k + 1), 1);
    end
    // Guard set: RAM and clock burst writes are blocked
    wq[0] = 8'hc8;
    wr_frame(CMD_CTRL_WR, 1);
    wq[0] = ~v0;
    wr_frame(CMD_RAM_FIRST, 1);
    exp_q.push_back(v0);
    rd_frame(CMD_RAM_FIRST + 8'h01, 1);
    clk = '{RST_SEC, RST_MIN, RST_HR, RST_DATE, RST_MON, RST_DAY, RST_YR, 8'hc8};
    wq = '{8'h11, 8'h22, 8'h13, 8'h14, 8'h05, 8'h06, 8'h27, 8'hc8};
    wr_frame(CMD_CLK_BURST_WR, 8);
    foreach (clk[i]) exp_q.push_back(clk[i]);
    rd_frame(CMD_CLK_BURST_RD, 8);
    wq[0] = 8'h48;
    wr_frame(CMD_CTRL_WR, 1);
    // Full burst write with 12-hour PM hours, then burst read back
    clk = '{8'h12, 8'h34, 8'hb1, 8'h15, 8'h08, 8'h03, 8'h24, 8'h48};
    wq = clk;
    wr_frame(CMD_CLK_BURST_WR, 8);
    foreach (clk[i]) exp_q.push_back(clk[i]);
    rd_frame(CMD_CLK_BURST_RD, 8);
    // Short burst: nothing changes; then a single seconds write lands
    wq = '{8'h59, 8'h59, 8'h09, 8'h28, 8'h02, 8'h07, 8'h99, 8'h48};
    wr_frame(CMD_CLK_BURST_WR, 4);
    wq[0] = 8'h42;
    wr_frame(CMD_SEC_WR, 1);
    clk[0] = 8'h42;
    foreach (clk[i]) exp_q.push_back(clk[i]);
    rd_frame(CMD_CLK_BURST_RD, 8);
    // RAM burst of three bytes from the first location
    foreach (wq[i]) wq[i] = 8'($urandom);
    wr_frame(CMD_RAM_BURST_WR, 3);
    for (int i = 0; i < 3; i++) exp_q.push_back(wq[i]);
    rd_frame(CMD_RAM_BURST_RD, 3);
    wrap_up();
  end
endmodule : rsr_core_tb_top
`default_nettype wire
